// file: src/fes_flash_seq.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fes_flash_seq
	import fes_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ,
	parameter int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ
) (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Pins from outside the clock domain.
	input  wire logic        user_boot_pin,
	input  wire logic        standby_req,
	// Status toward the rest of the chip.
	output logic             standby_grant,
	output logic             flash_lock,
	output logic             int_inhibit,
	output logic             boot_array_sel,
	output logic             embedded_sel,
	// Flash array strobes.
	output logic             erase_req,
	output logic             prog_req,
	output logic [7:0]       op_block
);

	typedef struct packed {
		fes_state_e       st;
		logic [1:0]       boot_cnt;
		logic             ub_sync1;
		logic             ub_sync2;
		logic             sb_sync1;
		logic             sb_sync2;
		logic             ub_mode;
		logic [31:0]      download_target_addr_reg;
		logic             prog_sel;
		logic             dl_err;
		logic [1:0]       dl_valid;
		logic [1:0]       init_ok;
		logic [31:0]      base_erase;
		logic [31:0]      base_prog;
		logic [7:0]       flash_key_reg;
		logic [7:0]       array_select_reg;
		logic             mat_boot;
		logic             mat_target;
		logic [7:0]       erase_block_select_param;
		logic [7:0]       op_frequency_param;
		logic [31:0]      program_data_pointer_param;
		logic [31:0]      program_dest_addr_param;
		logic [7:0]       result_flag_param;
		logic             tmr_start;
		logic [TMR_W-1:0] tmr_load;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
		logic             standby_grant;
		logic             flash_lock;
		logic             int_inhibit;
		logic             embedded_sel;
		logic             erase_req;
		logic             prog_req;
	} fes_top_s;

	fes_top_s s;
	fes_top_s n;

	logic        tmr_done;
	logic        hit;
	logic [31:0] rd;
	logic        wr;
	logic        call_erase;
	logic        call_prog;
	logic [7:0]  err;

	// Operation timer shared by the check, download, erase, program and switch states; boot counts with boot_cnt.
	fes_op_timer u_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (s.tmr_start),
		.load    (s.tmr_load),
		.done    (tmr_done)
	);

	// =========================================================
	// Next-state logic
	// =========================================================
	// Bus decode, sequencer and output flops all settle here.
	always_comb begin
		n = s;
		n.ub_sync1 = user_boot_pin;
		n.ub_sync2 = s.ub_sync1;
		n.sb_sync1 = standby_req;
		n.sb_sync2 = s.sb_sync1;
		n.tmr_start = 1'b0;
		n.erase_req = 1'b0;
		n.prog_req  = 1'b0;
		n.pready    = 1'b0;
		n.pslverr   = 1'b0;
		call_erase = 1'b0;
		call_prog  = 1'b0;
		err = RES_OK;
		hit = 1'b1;
		rd  = '0;
		// Read decode; unmapped offsets answer with an error.
		if (paddr == OFS_TDAR) begin
			rd = s.download_target_addr_reg;
		end else if (paddr == OFS_CCS) begin
			rd[CCS_PSEL_BIT]  = s.prog_sel;
			rd[CCS_DLERR_BIT] = s.dl_err;
		end else if (paddr == OFS_KEY) begin
			rd[7:0] = s.flash_key_reg;
		end else if (paddr == OFS_MATS) begin
			rd[7:0] = s.array_select_reg;
		end else if (paddr == OFS_ERASE_BLOCK_SELECT_PARAM) begin
			rd[7:0] = s.erase_block_select_param;
		end else if (paddr == OFS_FREQ) begin
			rd[7:0] = s.op_frequency_param;
		end else if (paddr == OFS_MPDR) begin
			rd = s.program_data_pointer_param;
		end else if (paddr == OFS_MPAR) begin
			rd = s.program_dest_addr_param;
		end else if (paddr == OFS_CALL) begin
			rd = '0;
		end else if (paddr == OFS_RESULT) begin
			rd[7:0] = s.result_flag_param;
		end else if (paddr == OFS_STATUS) begin
			rd = {21'h000000, s.st, s.init_ok, s.ub_mode, s.mat_boot};
		end else begin
			hit = 1'b0;
		end
		// Access phase answered after one wait cycle.
		if (psel && penable && !s.pready) begin
			n.pready  = 1'b1;
			n.pslverr = !hit;
			n.prdata  = hit ? rd : '0;
		end
		wr = psel && penable && s.pready && pwrite && !s.pslverr;

		case (s.st)
			ST_BOOT: begin
				// Wait for the mode pin synchroniser, then latch it.
				if (s.boot_cnt == BOOT_WAIT) begin
					n.ub_mode = s.ub_sync2;
					if (s.ub_sync2) begin
						n.st = ST_CHECK;
						n.tmr_start = 1'b1;
						n.tmr_load = TMR_W'(CHECK_CYCLES);
					end else begin
						n.st = ST_IDLE;
					end
				end else begin
					n.boot_cnt = s.boot_cnt + 2'h1;
				end
			end
			ST_CHECK: begin
				if (tmr_done) begin
					n.st = ST_IDLE;
					n.array_select_reg = MAT_BOOT_CODE;
					n.mat_boot = 1'b1;
				end
			end
			ST_IDLE: begin
				if (wr && paddr == OFS_TDAR) begin
					n.download_target_addr_reg = pwdata;
				end else if (wr && paddr == OFS_KEY) begin
					n.flash_key_reg = pwdata[7:0];
				end else if (wr && paddr == OFS_ERASE_BLOCK_SELECT_PARAM) begin
					n.erase_block_select_param = pwdata[7:0];
				end else if (wr && paddr == OFS_FREQ) begin
					n.op_frequency_param = pwdata[7:0];
				end else if (wr && paddr == OFS_MPDR) begin
					n.program_data_pointer_param = pwdata;
				end else if (wr && paddr == OFS_MPAR) begin
					n.program_dest_addr_param = pwdata;
				end else if (wr && paddr == OFS_CCS) begin
					n.prog_sel = pwdata[CCS_PSEL_BIT];
					if (pwdata[CCS_SCO_BIT]) begin
						if (s.flash_key_reg == KEY_DLOAD) begin
							n.st = ST_DLOAD;
							n.dl_err = 1'b0;
							n.tmr_start = 1'b1;
							n.tmr_load = TMR_W'(DLOAD_CYCLES);
						end else begin
							n.dl_err = 1'b1;
						end
					end
				end else if (wr && paddr == OFS_MATS && s.ub_mode) begin
					// Array switch only exists in user boot mode.
					if (pwdata[7:0] == MAT_BOOT_CODE ||
					    pwdata[7:0] == MAT_USER_CODE) begin
						n.st = ST_SWITCH;
						n.array_select_reg = pwdata[7:0];
						n.mat_target = pwdata[7:0] == MAT_BOOT_CODE;
						n.tmr_start = 1'b1;
						n.tmr_load = TMR_W'(SWITCH_CYCLES);
					end
				end else if (wr && paddr == OFS_CALL) begin
					// Calls only reach a routine that was downloaded.
					if (s.dl_valid[0] &&
					    pwdata == s.base_erase + INIT_OFS) begin
						n.init_ok[0] = s.op_frequency_param >= FREQ_MIN &&
							s.op_frequency_param <= FREQ_MAX;
						n.result_flag_param = n.init_ok[0] ? RES_OK :
							8'h01 << RES_FREQ_BIT;
					end else if (s.dl_valid[1] &&
					    pwdata == s.base_prog + INIT_OFS) begin
						n.init_ok[1] = s.op_frequency_param >= FREQ_MIN &&
							s.op_frequency_param <= FREQ_MAX;
						n.result_flag_param = n.init_ok[1] ? RES_OK :
							8'h01 << RES_FREQ_BIT;
					end else if (s.dl_valid[0] &&
					    pwdata == s.base_erase + ENTRY_OFS) begin
						call_erase = 1'b1;
						err[RES_KEY_BIT] =
							s.flash_key_reg != KEY_RUN;
						err[RES_BLOCK_BIT] =
							s.erase_block_select_param >= NUM_BLOCKS;
						err[RES_MAT_BIT] = s.ub_mode && s.mat_boot;
						err[RES_FREQ_BIT] = !s.init_ok[0];
					end else if (s.dl_valid[1] &&
					    pwdata == s.base_prog + ENTRY_OFS) begin
						call_prog = 1'b1;
						err[RES_KEY_BIT] = s.flash_key_reg != KEY_RUN;
						err[RES_PTR_BIT] = fes_in_flash(
							s.program_data_pointer_param);
						err[RES_ADDR_BIT] =
							!fes_in_flash(s.program_dest_addr_param) ||
							(s.program_dest_addr_param[6:0] & PAGE_MASK)
								!= 7'h00;
						err[RES_MAT_BIT] = s.ub_mode && s.mat_boot;
						err[RES_FREQ_BIT] = !s.init_ok[1];
					end
					if ((call_erase || call_prog) && err != RES_OK) begin
						n.result_flag_param = err;
					end else if (call_erase) begin
						n.st = ST_ERASE;
						n.erase_req = 1'b1;
						n.tmr_start = 1'b1;
						n.tmr_load = TMR_W'(ERASE_CYCLES);
					end else if (call_prog) begin
						n.st = ST_PROG;
						n.prog_req = 1'b1;
						n.tmr_start = 1'b1;
						n.tmr_load = TMR_W'(PROG_CYCLES);
					end
				end
			end
			ST_DLOAD: begin
				// One download per routine; its base is kept.
				if (tmr_done) begin
					n.st = ST_IDLE;
					if (s.prog_sel) begin
						n.dl_valid[1] = 1'b1;
						n.init_ok[1]  = 1'b0;
						n.base_prog   = s.download_target_addr_reg;
					end else begin
						n.dl_valid[0] = 1'b1;
						n.init_ok[0]  = 1'b0;
						n.base_erase  = s.download_target_addr_reg;
					end
				end
			end
			ST_ERASE, ST_PROG: begin
				if (tmr_done) begin
					n.st = ST_IDLE;
					n.result_flag_param = RES_OK;
				end
			end
			ST_SWITCH: begin
				if (tmr_done) begin
					n.st = ST_IDLE;
					n.mat_boot = s.mat_target;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// Flash locked during erase, program, switch and check; standby granted only in idle.
		n.flash_lock = n.st == ST_ERASE || n.st == ST_PROG ||
			n.st == ST_SWITCH || n.st == ST_CHECK;
		n.int_inhibit = n.st == ST_CHECK || n.st == ST_SWITCH;
		n.embedded_sel = n.st == ST_DLOAD;
		n.standby_grant = s.sb_sync2 && n.st == ST_IDLE;
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.st <= ST_BOOT;
		end else begin
			s <= n;
		end
	end

	// Outputs come straight from the state flops.
	assign pready         = s.pready;
	assign prdata         = s.prdata;
	assign pslverr        = s.pslverr;
	assign standby_grant  = s.standby_grant;
	assign flash_lock     = s.flash_lock;
	assign int_inhibit    = s.int_inhibit;
	assign boot_array_sel = s.mat_boot;
	assign embedded_sel   = s.embedded_sel;
	assign erase_req      = s.erase_req;
	assign prog_req       = s.prog_req;
	assign op_block       = s.erase_block_select_param;

	// =========================================================
	// Assertions
	// =========================================================
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_check_intblk: assert property (
		s.st == ST_CHECK |-> int_inhibit && flash_lock)
		else $error("interrupts not blocked during boot check");
	a_check_exit: assert property (
		$fell(s.st == ST_CHECK) |->
		s.array_select_reg == MAT_BOOT_CODE && boot_array_sel)
		else $error("boot array not selected after check");
	a_erase_lock: assert property (
		s.st == ST_ERASE |-> flash_lock && !standby_grant)
		else $error("flash or standby open during erase");
	a_key_guard: assert property (
		call_erase && s.flash_key_reg != KEY_RUN |=>
		s.st == ST_IDLE && s.result_flag_param[RES_KEY_BIT])
		else $error("erase ran without the key");
	a_block_range: assert property (
		$rose(s.st == ST_ERASE) |->
		s.erase_block_select_param < NUM_BLOCKS && erase_req)
		else $error("erase started on an invalid block");
	a_boot_prot: assert property (
		$rose(s.st == ST_ERASE) |-> !(s.ub_mode && s.mat_boot))
		else $error("boot array erased in user boot mode");
	a_entry_addr: assert property (
		$rose(s.st == ST_ERASE) |->
		$past(pwdata) == s.base_erase + ENTRY_OFS)
		else $error("erase entered at the wrong address");
	a_erase_result: assert property (
		$fell(s.st == ST_ERASE) |-> s.result_flag_param == RES_OK)
		else $error("erase finished without a clean result");
	a_ptr_guard: assert property (
		call_prog && fes_in_flash(s.program_data_pointer_param) |=>
		s.st == ST_IDLE && s.result_flag_param[RES_PTR_BIT])
		else $error("program ran with data inside flash");
	a_switch_time: assert property (
		$rose(s.st == ST_SWITCH) |-> flash_lock [*3] ##[1:20]
		s.st == ST_IDLE)
		else $error("array switch lock wrong");

	c_erase_done: cover property ($fell(s.st == ST_ERASE));
	c_check_done: cover property ($fell(s.st == ST_CHECK));
	c_switch_done: cover property ($fell(s.st == ST_SWITCH));
	c_init_ok: cover property ($rose(s.init_ok[0]));

endmodule // fes_flash_seq

// file: src/fes_pkg.sv
package fes_pkg;

	// =========================================================
	// Clock and timing
	// =========================================================
	localparam int CLK_MHZ        = 100;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int ERASE_TIME_US  = 1000;
	localparam int PROG_TIME_US   = 200;
	localparam int CHECK_TIME_US  = 20;
	localparam int DLOAD_TIME_US  = 2;
	localparam int SWITCH_TIME_NS = 100;
	localparam int CHECK_CYCLES   = CHECK_TIME_US * CLK_MHZ;
	localparam int DLOAD_CYCLES   = DLOAD_TIME_US * CLK_MHZ;
	localparam int SWITCH_CYCLES  =
		(SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W          = 20;
	localparam logic [1:0] BOOT_WAIT = 2'h3;

	// =========================================================
	// Register byte offsets
	// =========================================================
	localparam logic [11:0] OFS_TDAR   = 12'h000;
	localparam logic [11:0] OFS_CCS    = 12'h004;
	localparam logic [11:0] OFS_KEY    = 12'h008;
	localparam logic [11:0] OFS_MATS   = 12'h00c;
	localparam logic [11:0] OFS_ERASE_BLOCK_SELECT_PARAM   = 12'h010;
	localparam logic [11:0] OFS_FREQ   = 12'h014;
	localparam logic [11:0] OFS_MPDR   = 12'h018;
	localparam logic [11:0] OFS_MPAR   = 12'h01c;
	localparam logic [11:0] OFS_CALL   = 12'h020;
	localparam logic [11:0] OFS_RESULT = 12'h024;
	localparam logic [11:0] OFS_STATUS = 12'h028;

	// =========================================================
	// Values, fields and ranges
	// =========================================================
	localparam logic [31:0] ENTRY_OFS     = 32'h0000_0010;
	localparam logic [31:0] INIT_OFS      = 32'h0000_0020;
	localparam logic [7:0]  KEY_RUN       = 8'h5a;
	localparam logic [7:0]  KEY_DLOAD     = 8'ha5;
	localparam logic [7:0]  MAT_BOOT_CODE = 8'haa;
	localparam logic [7:0]  MAT_USER_CODE = 8'h00;
	localparam logic [7:0]  FREQ_MIN      = 8'h15;
	localparam logic [7:0]  FREQ_MAX      = 8'h22;
	localparam logic [7:0]  NUM_BLOCKS    = 8'h08;
	localparam logic [31:0] FLASH_END     = 32'h0002_0000;
	localparam logic [6:0]  PAGE_MASK     = 7'h7f;
	localparam logic [7:0]  RES_OK        = 8'h00;
	localparam int RES_KEY_BIT   = 1;
	localparam int RES_BLOCK_BIT = 2;
	localparam int RES_MAT_BIT   = 3;
	localparam int RES_PTR_BIT   = 4;
	localparam int RES_FREQ_BIT  = 5;
	localparam int RES_ADDR_BIT  = 6;
	localparam int CCS_SCO_BIT   = 0;
	localparam int CCS_PSEL_BIT  = 1;
	localparam int CCS_DLERR_BIT = 7;

	// Sequencer states, one-hot.
	typedef enum logic [6:0] {
		ST_BOOT   = 7'h01,
		ST_CHECK  = 7'h02,
		ST_IDLE   = 7'h04,
		ST_DLOAD  = 7'h08,
		ST_ERASE  = 7'h10,
		ST_PROG   = 7'h20,
		ST_SWITCH = 7'h40
	} fes_state_e;

	// True when an address falls inside the user flash array.
	function automatic logic fes_in_flash(input logic [31:0] addr);
		return addr < FLASH_END;
	endfunction

endpackage

// file: src/fes_op_timer.sv
`timescale 1ns/1ps
module fes_op_timer
	import fes_pkg::*;
(
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Start with a cycle count, done pulse at the end.
	input  wire logic             start,
	input  wire logic [TMR_W-1:0] load,
	output logic                  done
);

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             run;
		logic             done;
	} fes_tmr_s;

	fes_tmr_s tmr_reg;
	fes_tmr_s tmr_next;

	// =========================================================
	// Countdown
	// =========================================================
	// A start reloads the count; done pulses once the count runs out.
	always_comb begin
		tmr_next = tmr_reg;
		tmr_next.done = 1'b0;
		if (start) begin
			tmr_next.cnt = load;
			tmr_next.run = 1'b1;
		end else if (tmr_reg.run) begin
			if (tmr_reg.cnt <= TMR_W'(1)) begin
				tmr_next.run  = 1'b0;
				tmr_next.done = 1'b1;
			end else begin
				tmr_next.cnt = tmr_reg.cnt - TMR_W'(1);
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tmr_reg <= '0;
		end else begin
			tmr_reg <= tmr_next;
		end
	end

	assign done = tmr_reg.done;

endmodule // fes_op_timer

// file: bench/fes_cpu_model.sv
`timescale 1ns/1ps
// =========================================================
// Processor side of the register bus
// =========================================================
module fes_cpu_model (
	// Clock.
	input  wire logic        ref_clk,
	// APB master toward the sequencer.
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	logic [31:0] rd_data;
	logic        rd_err;

	// The bus starts idle.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// One transfer; the request is held until pready is seen high.
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the bench watchdog ends a wait for the answer.
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released write data shows no stale value.
		pwdata <= ~d;
	endtask
endmodule // fes_cpu_model

// file: bench/flash_erase_and_bank_switch_test.sv
`timescale 1ns/1ps
// =========================================================
// Erase and array switch bench
// =========================================================
module flash_erase_and_bank_switch_test;
	import fes_pkg::*;
	localparam logic [31:0] BASE = 32'h0000_1000;
	// Program routine sits apart, 512 bytes above the erase routine.
	localparam logic [31:0] PBASE = BASE + 32'h0000_0200;
	logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        user_boot_pin, standby_req, standby_grant, flash_lock;
	logic        int_inhibit, boot_array_sel, embedded_sel;
	logic        erase_req, prog_req;
	logic [7:0]  op_block;
	int          mismatches, compares, blk;
	logic [7:0]  blk_q[$];

	fes_flash_seq #(.ERASE_CYCLES(50), .PROG_CYCLES(50)) fes_flash_seq_inst (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .user_boot_pin(user_boot_pin),
		.standby_req(standby_req), .standby_grant(standby_grant),
		.flash_lock(flash_lock), .int_inhibit(int_inhibit),
		.boot_array_sel(boot_array_sel), .embedded_sel(embedded_sel),
		.erase_req(erase_req), .prog_req(prog_req), .op_block(op_block));

	fes_cpu_model fes_cpu_model_inst (
		.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));

	// Compares one value and reports a difference at once.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Polls status until the sequencer is idle again.
	task automatic wait_idle;
		do begin
			fes_cpu_model_inst.xfer(1'b0, OFS_STATUS, 32'h0);
		end while (fes_cpu_model_inst.rd_data[6] !== 1'b1);
	endtask

	// Expected result byte of one erase call.
	function automatic logic [31:0] exp_res(logic [7:0] key, logic [7:0] b,
		logic boot);
		exp_res = 32'h0;
		exp_res[RES_KEY_BIT] = (key != KEY_RUN);
		exp_res[RES_BLOCK_BIT] = (b >= NUM_BLOCKS);
		exp_res[RES_MAT_BIT] = boot;
	endfunction

	// One erase call with its parameters, then the result check.
	task automatic erase(input logic [7:0] key, input logic [7:0] b,
		input logic boot);
		logic [31:0] e;
		e = exp_res(key, b, boot);
		fes_cpu_model_inst.xfer(1'b1, OFS_KEY, 32'(key));
		fes_cpu_model_inst.xfer(1'b1, OFS_ERASE_BLOCK_SELECT_PARAM, 32'(b));
		if (e == 32'h0) begin
			blk_q.push_back(b);
		end
		fes_cpu_model_inst.xfer(1'b1, OFS_CALL, BASE + ENTRY_OFS);
		if (e == 32'h0) begin
			repeat (3) @(posedge ref_clk);
			chk(32'(flash_lock), 32'h1);
			chk(32'(standby_grant), 32'h0);
		end
		wait_idle();
		fes_cpu_model_inst.xfer(1'b0, OFS_RESULT, 32'h0);
		chk(fes_cpu_model_inst.rd_data, e);
	endtask

	// Every erase strobe must match the next block the model expects.
	always @(posedge ref_clk) begin
		if (erase_req === 1'b1) begin
			if (blk_q.size() == 0) begin
				chk(32'h1, 32'h0);
			end else begin
				chk(32'(op_block), 32'(blk_q.pop_front()));
			end
		end
		if (prog_req === 1'b1) begin
			chk(32'h1, 32'h0);
		end
	end

	// Free running clock.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Cuts a hang short.
	initial begin
		repeat (50000) @(posedge ref_clk);
		mismatches++;
		stop_test();
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		user_boot_pin = 1'b1;
		standby_req = 1'b0;
		mismatches = 0;
		compares = 0;
		void'($urandom(39));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk(32'(int_inhibit), 32'h1);
		chk(32'(flash_lock), 32'h1);
		wait_idle();
		chk(32'(boot_array_sel), 32'h1);
		fes_cpu_model_inst.xfer(1'b0, OFS_MATS, 32'h0);
		chk(fes_cpu_model_inst.rd_data, 32'(MAT_BOOT_CODE));
		fes_cpu_model_inst.xfer(1'b0, 12'h0fc, 32'h0);
		chk(32'(fes_cpu_model_inst.rd_err), 32'h1);
		// Download the erase routine and initialise it.
		fes_cpu_model_inst.xfer(1'b1, OFS_KEY, 32'(KEY_DLOAD));
		fes_cpu_model_inst.xfer(1'b1, OFS_TDAR, BASE);
		fes_cpu_model_inst.xfer(1'b1, OFS_CCS, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk(32'(embedded_sel), 32'h1);
		chk(32'(flash_lock), 32'h0);
		wait_idle();
		fes_cpu_model_inst.xfer(1'b1, OFS_FREQ,
			32'(FREQ_MIN) + ($urandom % 14));
		fes_cpu_model_inst.xfer(1'b1, OFS_CALL, BASE + INIT_OFS);
		wait_idle();
		fes_cpu_model_inst.xfer(1'b0, OFS_RESULT, 32'h0);
		chk(fes_cpu_model_inst.rd_data, 32'h0);
		standby_req <= 1'b1;
		erase(KEY_RUN, 8'h00, 1'b1);
		// Switch to the user array for the erase calls.
		fes_cpu_model_inst.xfer(1'b1, OFS_MATS, 32'(MAT_USER_CODE));
		repeat (3) @(posedge ref_clk);
		chk(32'(int_inhibit), 32'h1);
		chk(32'(flash_lock), 32'h1);
		wait_idle();
		chk(32'(boot_array_sel), 32'h0);
		blk = $urandom % 8;
		erase(KEY_RUN, 8'(blk), 1'b0);
		erase(KEY_RUN, 8'(blk), 1'b0);
		erase(KEY_RUN, NUM_BLOCKS, 1'b0);
		erase(8'h00, 8'h01, 1'b0);
		erase(KEY_RUN, 8'h07, 1'b0);
		// Program routine: download, initialise, then a data pointer in flash.
		fes_cpu_model_inst.xfer(1'b1, OFS_KEY, 32'(KEY_DLOAD));
		fes_cpu_model_inst.xfer(1'b1, OFS_TDAR, PBASE);
		fes_cpu_model_inst.xfer(1'b1, OFS_CCS, 32'h3);
		wait_idle();
		fes_cpu_model_inst.xfer(1'b1, OFS_CALL, PBASE + INIT_OFS);
		fes_cpu_model_inst.xfer(1'b0, OFS_RESULT, 32'h0);
		chk(fes_cpu_model_inst.rd_data, 32'h0);
		fes_cpu_model_inst.xfer(1'b1, OFS_KEY, 32'(KEY_RUN));
		fes_cpu_model_inst.xfer(1'b1, OFS_MPDR, 32'h0000_0100);
		fes_cpu_model_inst.xfer(1'b1, OFS_MPAR, 32'h0);
		fes_cpu_model_inst.xfer(1'b1, OFS_CALL, PBASE + ENTRY_OFS);
		fes_cpu_model_inst.xfer(1'b0, OFS_RESULT, 32'h0);
		chk(fes_cpu_model_inst.rd_data, 32'h1 << RES_PTR_BIT);
		// A call to a wrong entry address starts nothing.
		fes_cpu_model_inst.xfer(1'b1, OFS_CALL, BASE + 32'h4);
		repeat (5) @(posedge ref_clk);
		chk(32'(flash_lock), 32'h0);
		chk(32'(standby_grant), 32'h1);
		fes_cpu_model_inst.xfer(1'b1, OFS_MATS, 32'(MAT_BOOT_CODE));
		wait_idle();
		chk(32'(boot_array_sel), 32'h1);
		fes_cpu_model_inst.xfer(1'b1, OFS_KEY, 32'h0);
		chk(32'(blk_q.size()), 32'h0);
		stop_test();
	end
endmodule // flash_erase_and_bank_switch_test
